// [flsc_flash_model.sv]
/*
 Flash device model: command decode, status byte, lock ops, OTP words.
 Assumes host pins change on clk_sys edges; word mode only.
*/
`default_nettype none
module flsc_flash_model
    import flsc_pkg::*;
(
    // Clock and host pins
    input wire logic clk_sys,
    input wire flsc_pins_t pins,
    input wire logic hard_reset_pin_n,
    // Answers
    output logic [15:0] dq_in,
    output logic status_output_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] otp [0:8];
    logic [15:0] last, val;
    logic [7:0] sr, d;
    logic [1:0] mode, pend, sts, kind;
    logic [3:0] w;
    logic we_q, err;
    int busy, pulse;
    // Factory words are arbitrary
    initial begin
        for (int i = 0; i < 9; i++) begin
            otp[i] = (i > 4) ? 16'hFFFF : 16'hA500 + i[15:0];
        end
        otp[0] = 16'hFFFE;
        {sr, mode, pend, sts, kind, we_q, last, busy, pulse} = '0;
    end
    // Commands act on the rising edge of the write strobe
    always @(posedge clk_sys) begin
        we_q <= pins.we_n;
        if (busy > 0) busy <= busy - 1;
        if (pulse > 0) pulse <= pulse - 1;
        if (busy == 1 && (kind & sts) != 2'h0) pulse <= 25;
        if (!hard_reset_pin_n) begin
            {mode, pend, sts, busy} <= '0;
        end else if (!we_q && pins.we_n) begin
            d = pins.dq_out[7:0];
            w = pins.addr[4:1];
            pend <= 2'h0;
            case (pend)
                2'h1: begin
                    sts <= d[1:0];
                    if (d[7:2] != 6'h0) sr <= sr | 8'h30;
                end
                2'h2: if (d == 8'h01 || d == 8'hD0) begin
                    busy <= pins.addr[23] ? 500 : 40;
                    kind <= (d == 8'h01) ? 2'h2 : 2'h1;
                end
                2'h3: begin
                    busy <= 40;
                    kind <= 2'h2;
                    err = pins.addr[23:5] != 19'h8 || w > 4'h8 || (w > 4'h0 && !otp[0][w > 4'h4]);
                    if (err) sr <= sr | 8'h10;
                    else otp[w] <= otp[w] & pins.dq_out;
                end
                default: case (d)
                    8'hFF: mode <= 2'h0;
                    8'h70: mode <= 2'h1;
                    8'h50: sr <= 8'h0;
                    8'h90: mode <= 2'h2;
                    8'h60, 8'hC0, 8'hB8: if (busy == 0) begin
                        pend <= (d == 8'hB8) ? 2'h1 : (d == 8'h60) ? 2'h2 : 2'h3;
                        mode <= 2'h1;
                    end
                    default: ;
                endcase
            endcase
        end
    end
    // Read data; status reads return all zero, ready bit included, while busy
    always_comb begin
        if (mode == 2'h1) val = (busy > 0) ? 16'h0 : {8'h0, 8'h80 | sr};
        else if (mode == 2'h2) val = otp[pins.addr[4:1]];
        else val = pins.addr[15:0] ^ 16'h5A5A;
    end
    always @(posedge clk_sys) if (!pins.ce_n && !pins.oe_n) last <= val;
    // Released bus never shows the last value
    assign dq_in = (!pins.ce_n && !pins.oe_n) ? val : ~last;
    assign status_output_pin = (sts == 2'h0) ? (busy == 0) : (pulse == 0);
endmodule // flsc_flash_model
`default_nettype wire

// [flsc_host.sv]
/*
 Host controller that sequences status pin configuration, lock bit commands and OTP register
 access on a parallel NOR flash, with a small software register port.
 Assumes flash pin inputs are synchronous to clk_sys and the flash answers at its documented timing.
*/
// The placing of the registers and the address-and-strobe port were left to the implementer.
`include "flsc_params.svh"
`default_nettype none
module flsc_host
    import flsc_pkg::*;
#(
    parameter int POLL_LIMIT = `FLSC_POLL_LIMIT
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Software register port
    input wire flsc_sw_req_t sw_req,
    output logic [31:0] sw_rdata,
    // Flash pins
    input wire logic [15:0] dq_in,
    input wire logic status_output_pin,
    output flsc_pins_t pins,
    output logic hard_reset_pin_n
);
    typedef struct packed {
        flsc_state_t state;
        flsc_op_t op;
        logic issued;
        logic [23:0] addr;
        logic [15:0] wdata;
        logic [2:0] cfg;
        logic [3:0] rst_cnt;
        logic [1:0] sts_mode;
        logic refused;
        logic timeout;
        logic [7:0] last_sr;
        logic [15:0] rdata;
        logic [7:0] pulses;
        logic sts_q;
        logic [19:0] poll_cnt;
        logic [31:0] sw_rdata;
        flsc_cyc_t cyc;
    } flsc_host_st_t;
    localparam flsc_host_st_t RST = '{state: S_IDLE, op: OP_RD_ARRAY, issued: 1'b0, addr: 24'h000000,
        wdata: 16'h0000, cfg: `FLSC_CFG_RESET, rst_cnt: 4'h0, sts_mode: 2'h0, refused: 1'b0,
        timeout: 1'b0, last_sr: 8'h00, rdata: 16'h0000, pulses: 8'h00, sts_q: 1'b1,
        poll_cnt: 20'h00000, sw_rdata: 32'h00000000, cyc: '0};
    flsc_host_st_t st_ff, nxt_st;
    logic cyc_done;
    logic [15:0] cyc_rdata;

    // OTP pin address: high lines zero, A0 unused in word mode
    function automatic logic [23:0] otp_addr(input logic byte_mode, input logic [8:0] idx);
        otp_addr = byte_mode ? {15'h0000, idx} : {15'h0000, idx[7:0], 1'b0}; // R24 R23
    endfunction

    function automatic logic [7:0] first_cmd(input flsc_op_t op);
        unique case (op)
            OP_RD_ARRAY: first_cmd = `FLSC_CMD_READ_ARRAY; // R17
            OP_RD_STATUS: first_cmd = `FLSC_CMD_READ_STATUS;
            OP_CLR_STATUS: first_cmd = `FLSC_CMD_CLR_STATUS; // R25
            OP_SET_LOCK, OP_CLR_LOCKS: first_cmd = `FLSC_CMD_LOCK_SETUP; // R11
            OP_CFG_STS: first_cmd = `FLSC_CMD_STS_CFG; // R6
            OP_OTP_PROG, OP_OTP_LOCK: first_cmd = `FLSC_CMD_OTP_PROG; // R18
            OP_OTP_READ: first_cmd = `FLSC_CMD_READ_ID; // R17
            default: first_cmd = `FLSC_CMD_READ_ARRAY;
        endcase
    endfunction

    function automatic logic needs_check(input flsc_op_t op);
        needs_check = op inside {OP_SET_LOCK, OP_CLR_LOCKS, OP_CFG_STS, OP_OTP_PROG, OP_OTP_LOCK};
    endfunction

    flsc_pin_cycle u_cycle (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .req(st_ff.cyc),
        .done(cyc_done),
        .rdata(cyc_rdata),
        .dq_in(dq_in),
        .pins(pins)
    );

    assign sw_rdata = st_ff.sw_rdata;
    assign hard_reset_pin_n = ~st_ff.cfg[`FLSC_CFG_HRST];

    // Software port, sequencer and status pin watch in one process
    always_comb begin
        nxt_st = st_ff;
        nxt_st.cyc.start = 1'b0;
        nxt_st.sw_rdata = 32'h00000000;
        nxt_st.sts_q = status_output_pin;
        // Falling edges count as completion pulses only in pulse mode
        if (st_ff.sts_mode != 2'h0 && st_ff.sts_q && !status_output_pin) begin
            nxt_st.pulses = st_ff.pulses + 8'h01; // R10
        end
        if (sw_req.rd) begin
            unique case (sw_req.addr)
                `FLSC_REG_ADDR: nxt_st.sw_rdata = {8'h00, st_ff.addr};
                `FLSC_REG_WDATA: nxt_st.sw_rdata = {16'h0000, st_ff.wdata};
                `FLSC_REG_STATUS: nxt_st.sw_rdata = {8'h00, st_ff.pulses, st_ff.last_sr, 2'h0, st_ff.sts_mode,
                    1'b0, st_ff.timeout, st_ff.refused, st_ff.state != S_IDLE};
                `FLSC_REG_RDATA: nxt_st.sw_rdata = {16'h0000, st_ff.rdata};
                `FLSC_REG_CFG: nxt_st.sw_rdata = {29'h00000000, st_ff.cfg};
                default: nxt_st.sw_rdata = 32'h00000000;
            endcase
        end
        if (sw_req.wr) begin
            unique case (sw_req.addr)
                `FLSC_REG_ADDR: nxt_st.addr = sw_req.wdata[23:0];
                `FLSC_REG_WDATA: nxt_st.wdata = sw_req.wdata[15:0];
                `FLSC_REG_CFG: begin
                    nxt_st.cfg = sw_req.wdata[2:0]; // R1 R3
                    if (sw_req.wdata[`FLSC_CFG_HRST]) begin
                        nxt_st.rst_cnt = 4'(`FLSC_CYC_RP);
                    end
                end
                `FLSC_REG_CTRL: begin
                    // Orders while a sequence runs are dropped; software polls busy first
                    if (st_ff.state == S_IDLE && !st_ff.cfg[`FLSC_CFG_HRST] && sw_req.wdata[3:0] <= 4'h8) begin
                        nxt_st.op = flsc_op_t'(sw_req.wdata[3:0]);
                        nxt_st.refused = 1'b0;
                        nxt_st.timeout = 1'b0;
                        nxt_st.state = needs_check(flsc_op_t'(sw_req.wdata[3:0])) ? S_CHK_W : S_CMD1;
                    end
                end
                default: ;
            endcase
        end
        // States other than S_IDLE and S_DONE issue one pin cycle and move on when it completes; S_POLL repeats until ready or timeout
        if (st_ff.state != S_IDLE && st_ff.state != S_DONE && !st_ff.issued) begin
            nxt_st.issued = 1'b1;
            nxt_st.cyc.start = 1'b1;
            nxt_st.cyc.write = st_ff.state inside {S_CHK_W, S_CMD1, S_CMD2};
            nxt_st.cyc.addr = st_ff.addr;
            nxt_st.cyc.data = {8'h00, first_cmd(st_ff.op)};
            unique case (st_ff.state)
                S_CHK_W: nxt_st.cyc.data = {8'h00, `FLSC_CMD_READ_STATUS};
                S_CMD2: begin
                    unique case (st_ff.op)
                        OP_SET_LOCK: nxt_st.cyc.data = {8'h00, `FLSC_CMD_LOCK_SET}; // R11
                        OP_CLR_LOCKS: nxt_st.cyc.data = {8'h00, `FLSC_CMD_LOCK_CLR}; // R15
                        OP_CFG_STS: nxt_st.cyc.data = {14'h0000, st_ff.wdata[1:0]}; // R6 R7
                        OP_OTP_LOCK: begin
                            nxt_st.cyc.addr = {15'h0000, `FLSC_OTP_BASE};
                            nxt_st.cyc.data = `FLSC_OTP_LOCK_VAL; // R20
                        end
                        default: begin
                            nxt_st.cyc.addr = otp_addr(st_ff.cfg[`FLSC_CFG_BYTE], st_ff.addr[8:0]);
                            nxt_st.cyc.data = st_ff.cfg[`FLSC_CFG_BYTE] ? {8'h00, st_ff.wdata[7:0]} : st_ff.wdata; // R18
                        end
                    endcase
                end
                S_RD: begin
                    if (st_ff.op == OP_OTP_READ) begin
                        nxt_st.cyc.addr = otp_addr(st_ff.cfg[`FLSC_CFG_BYTE], st_ff.addr[8:0]);
                    end
                end
                default: ;
            endcase
        end else if (st_ff.issued && cyc_done) begin
            nxt_st.issued = 1'b0;
            unique case (st_ff.state)
                S_CHK_W: nxt_st.state = S_CHK_R;
                S_CHK_R: begin
                    nxt_st.last_sr = cyc_rdata[7:0];
                    if (!cyc_rdata[`FLSC_SR_READY]) begin
                        nxt_st.refused = 1'b1; // R8 R12
                        nxt_st.state = S_DONE;
                    end else begin
                        nxt_st.state = S_CMD1;
                    end
                end
                S_CMD1: begin
                    unique case (st_ff.op)
                        OP_RD_ARRAY, OP_RD_STATUS, OP_OTP_READ: nxt_st.state = S_RD;
                        OP_CLR_STATUS: nxt_st.state = S_DONE;
                        default: nxt_st.state = S_CMD2;
                    endcase
                end
                S_CMD2: begin
                    if (st_ff.op == OP_CFG_STS) begin
                        nxt_st.sts_mode = st_ff.wdata[1:0]; // R4 R5 R7
                        nxt_st.state = S_DONE;
                    end else begin
                        nxt_st.poll_cnt = 20'h00000;
                        nxt_st.state = S_POLL; // R13
                    end
                end
                S_POLL: begin
                    // Reads now return status; fail flags stay for software R9 R19 R25
                    nxt_st.last_sr = cyc_rdata[7:0];
                    if (cyc_rdata[`FLSC_SR_READY]) begin
                        nxt_st.state = S_DONE; // R26
                    end else if (st_ff.poll_cnt >= 20'(POLL_LIMIT)) begin
                        nxt_st.timeout = 1'b1;
                        nxt_st.state = S_DONE;
                    end else begin
                        nxt_st.poll_cnt = st_ff.poll_cnt + 20'h00001;
                    end
                end
                S_RD: begin
                    nxt_st.rdata = cyc_rdata;
                    if (st_ff.op == OP_RD_STATUS) begin
                        nxt_st.last_sr = cyc_rdata[7:0];
                    end
                    nxt_st.state = S_DONE;
                end
                default: ;
            endcase
        end
        // Hard reset last so it wins: level mode and array reads
        if (st_ff.cfg[`FLSC_CFG_HRST]) begin
            nxt_st.sts_mode = 2'h0; // R4 R22
            if (st_ff.rst_cnt == 4'h0) begin
                nxt_st.cfg[`FLSC_CFG_HRST] = 1'b0;
            end else begin
                nxt_st.rst_cnt = st_ff.rst_cnt - 4'h1;
            end
        end
        if (st_ff.state == S_DONE) begin
            nxt_st.state = S_IDLE;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_busy_refuses_op: // R8
        assert property (st_ff.state == S_CHK_R && st_ff.issued && cyc_done && !cyc_rdata[7]
            |=> st_ff.refused && st_ff.state == S_DONE ##1 st_ff.state == S_IDLE)
        else $error("busy device not refused");
    a_lock_no_busy: // R12
        assert property (st_ff.state == S_CMD1 && (st_ff.op == OP_SET_LOCK || st_ff.op == OP_CLR_LOCKS)
            |-> st_ff.last_sr[7])
        else $error("lock command without ready check");
    a_hard_reset_mode: // R4
        assert property (!hard_reset_pin_n |=> st_ff.sts_mode == 2'h0)
        else $error("status mode kept over hard reset");
    a_cfg_code_reserved: // R6
        assert property (!pins.we_n && st_ff.state == S_CMD2 && st_ff.op == OP_CFG_STS
            |-> pins.dq_out[15:2] == 14'h0000)
        else $error("reserved config code bits set");
    a_cfg_mode_update: // R7
        assert property (st_ff.state == S_CMD2 && st_ff.op == OP_CFG_STS && st_ff.issued && cyc_done
            |=> st_ff.sts_mode == $past(st_ff.wdata[1:0]))
        else $error("status mode not tracked");
    a_otp_high_zero: // R24
        assert property (!pins.ce_n && st_ff.state inside {S_CMD2, S_RD}
            && st_ff.op inside {OP_OTP_PROG, OP_OTP_LOCK, OP_OTP_READ} |-> pins.addr[23:9] == 15'h0000)
        else $error("otp access with high address lines");
    a_otp_word_a0: // R23
        assert property (!pins.ce_n && !st_ff.cfg[0] && st_ff.state == S_CMD2
            && st_ff.op inside {OP_OTP_PROG, OP_OTP_LOCK} |-> pins.addr[0] == 1'b0)
        else $error("A0 driven in word mode");
    a_otp_lock_value: // R20
        assert property (!pins.we_n && st_ff.state == S_CMD2 && st_ff.op == OP_OTP_LOCK
            |-> pins.dq_out == 16'hFFFD && pins.addr[8:0] == 9'h100)
        else $error("otp lock write wrong");
    a_poll_after_cmd: // R13
        assert property (st_ff.state == S_CMD2 && st_ff.op != OP_CFG_STS && st_ff.issued && cyc_done
            |=> st_ff.state == S_POLL ##[1:40] !pins.oe_n)
        else $error("no status poll after command");
    a_clear_status_cmd: // R25
        assert property (!pins.we_n && st_ff.state == S_CMD1 && st_ff.op == OP_CLR_STATUS
            |-> pins.dq_out[7:0] == 8'h50)
        else $error("clear status code wrong");
    c_refused: cover property (st_ff.refused && st_ff.state == S_DONE);
    c_pulse_seen: cover property (st_ff.sts_mode != 2'h0 && $changed(st_ff.pulses));
    c_lock_done: cover property (st_ff.state == S_POLL ##[1:200] st_ff.state == S_DONE);
    c_otp_read: cover property (st_ff.op == OP_OTP_READ && st_ff.state == S_RD ##[1:40] st_ff.state == S_DONE);
endmodule // flsc_host
`default_nettype wire

// [flsc_params.svh]
/*
 Constants for the flash status, lock and OTP host controller: offsets, fields, command codes, timing counts.
 Assumes a 100 MHz clk_sys and a flash device on the far side of the pins.
*/
// Notes on behaviour
// R1: Config bit 16 selects page reads
// R2: Status, query, ID reads are single reads
// R3: Reserved config bits 15..1 written zero
// R4: Status pin keeps config until reconfig/reset
// R5: Default status pin is ready/busy level
// R6: Command B8h then code; bits 7..2 zero
// R7: Code 00h restores level mode
// R8: Configure only when device ready
// R9: Invalid code sets both fail flags
// R10: Pulse mode drives status pin low briefly
// R11: Lock set is 60h then confirm at block
// R12: Lock commands rejected while device busy
// R13: After lock commands, reads return status
// R14: Low enable supply protects lock bits
// R15: Clear locks clears all; abort needs repeat
// R16: 128-bit OTP: factory and user halves
// R17: 90H enters ID mode; FFH returns array
// R18: C0H then one write programs OTP location
// R19: Bad OTP address or locked gives error
// R20: Lock user half by writing FFFD
// R21: OTP lock is permanent
// R22: Array read mode after power events
// R23: Word mode ignores A0 for OTP
// R24: OTP accesses drive A23..A9 zero
// R25: Fail flags stay until command 50H
// R26: Status bit 7 is ready flag
// R27: Pulse width counted from device clock
`ifndef FLSC_PARAMS_SVH
`define FLSC_PARAMS_SVH
// Software register offsets
`define FLSC_REG_CTRL 8'h00
`define FLSC_REG_ADDR 8'h04
`define FLSC_REG_WDATA 8'h08
`define FLSC_REG_STATUS 8'h0C
`define FLSC_REG_RDATA 8'h10
`define FLSC_REG_CFG 8'h14
// Config register fields
`define FLSC_CFG_BYTE 0
`define FLSC_CFG_PAGE 1
`define FLSC_CFG_HRST 2
`define FLSC_CFG_RESET 3'h0
// Status register fields
`define FLSC_ST_BUSY 0
`define FLSC_ST_REFUSED 1
`define FLSC_ST_TIMEOUT 2
`define FLSC_ST_MODE 4
`define FLSC_ST_SR 8
`define FLSC_ST_PULSES 16
// Flash command codes
`define FLSC_CMD_READ_ARRAY 8'hFF
`define FLSC_CMD_READ_STATUS 8'h70
`define FLSC_CMD_CLR_STATUS 8'h50
`define FLSC_CMD_LOCK_SETUP 8'h60
`define FLSC_CMD_LOCK_SET 8'h01
`define FLSC_CMD_LOCK_CLR 8'hD0
`define FLSC_CMD_STS_CFG 8'hB8
`define FLSC_CMD_OTP_PROG 8'hC0
`define FLSC_CMD_READ_ID 8'h90
`define FLSC_OTP_LOCK_VAL 16'hFFFD
`define FLSC_OTP_BASE 9'h100
`define FLSC_SR_READY 7
// Timing, figures in ns, counts in cycles
`define FLSC_CLK_NS 10
`define FLSC_T_WE_NS 70
`define FLSC_T_ACC_NS 120
`define FLSC_T_RP_NS 100
`define FLSC_CYC_WE ((`FLSC_T_WE_NS + `FLSC_CLK_NS - 1) / `FLSC_CLK_NS)
`define FLSC_CYC_ACC ((`FLSC_T_ACC_NS + `FLSC_CLK_NS - 1) / `FLSC_CLK_NS)
`define FLSC_CYC_RP ((`FLSC_T_RP_NS + `FLSC_CLK_NS - 1) / `FLSC_CLK_NS)
`define FLSC_POLL_LIMIT 1000000
`endif

// [flsc_pin_cycle.sv]
/*
 One asynchronous flash bus cycle, write or single read, timed in clk_sys cycles.
 Assumes start arrives only while idle and dq_in is synchronous to clk_sys.
*/
`include "flsc_params.svh"
`default_nettype none
module flsc_pin_cycle
    import flsc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Request and answer
    input wire flsc_cyc_t req,
    output logic done,
    output logic [15:0] rdata,
    // Flash pins
    input wire logic [15:0] dq_in,
    output flsc_pins_t pins
);
    typedef struct packed {
        flsc_phase_t phase;
        logic [3:0] cnt;
        logic write;
        flsc_pins_t pins;
        logic done;
        logic [15:0] rdata;
    } flsc_cyc_st_t;
    localparam flsc_cyc_st_t RST = '{phase: P_IDLE, cnt: 4'h0, write: 1'b0,
        pins: '{addr: 24'h000000, dq_out: 16'h0000, dq_oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1},
        done: 1'b0, rdata: 16'h0000};
    flsc_cyc_st_t st_ff, nxt_st;

    assign done = st_ff.done;
    assign rdata = st_ff.rdata;
    assign pins = st_ff.pins;

    // Setup one cycle, strobe for the timed width, then one idle hold cycle
    always_comb begin
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        unique case (st_ff.phase)
            P_IDLE: begin
                if (req.start) begin
                    nxt_st.phase = P_SETUP;
                    nxt_st.write = req.write;
                    nxt_st.pins.addr = req.addr;
                    nxt_st.pins.dq_out = req.data;
                    nxt_st.pins.ce_n = 1'b0;
                end
            end
            P_SETUP: begin
                nxt_st.phase = P_STROBE;
                nxt_st.pins.dq_oe = st_ff.write;
                nxt_st.pins.we_n = ~st_ff.write;
                nxt_st.pins.oe_n = st_ff.write; // Single read only, never page reads R2
                nxt_st.cnt = st_ff.write ? 4'(`FLSC_CYC_WE - 1) : 4'(`FLSC_CYC_ACC - 1);
            end
            P_STROBE: begin
                if (st_ff.cnt == 4'h0) begin
                    nxt_st.phase = P_HOLD;
                    nxt_st.pins.we_n = 1'b1;
                    nxt_st.pins.oe_n = 1'b1;
                    nxt_st.pins.ce_n = 1'b1;
                    if (!st_ff.write) begin
                        nxt_st.rdata = dq_in;
                    end
                end else begin
                    nxt_st.cnt = st_ff.cnt - 4'h1;
                end
            end
            P_HOLD: begin
                // Data held one cycle past the strobe for hold time
                nxt_st.phase = P_IDLE;
                nxt_st.pins.dq_oe = 1'b0;
                nxt_st.done = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_we_low_width: // R11
        assert property ($fell(pins.we_n) |-> !pins.we_n [*7] ##1 pins.we_n)
        else $error("write strobe width wrong");
    a_read_no_drive: // R2
        assert property (!pins.oe_n |-> !pins.dq_oe && pins.we_n)
        else $error("bus driven during read");
    c_write_cycle: cover property ($rose(pins.we_n) ##2 done);
endmodule // flsc_pin_cycle
`default_nettype wire

// [flsc_pkg.sv]
/*
 Types for the flash status, lock and OTP host controller.
 Assumes flsc_params.svh is compiled alongside.
*/
`default_nettype none
package flsc_pkg;
    typedef enum logic [2:0] {
        S_IDLE = 3'h0, S_CHK_W = 3'h1, S_CHK_R = 3'h3, S_CMD1 = 3'h2,
        S_CMD2 = 3'h6, S_POLL = 3'h7, S_RD = 3'h5, S_DONE = 3'h4
    } flsc_state_t;
    typedef enum logic [3:0] {
        OP_RD_ARRAY = 4'h0, OP_RD_STATUS = 4'h1, OP_CLR_STATUS = 4'h2, OP_SET_LOCK = 4'h3,
        OP_CLR_LOCKS = 4'h4, OP_CFG_STS = 4'h5, OP_OTP_PROG = 4'h6, OP_OTP_READ = 4'h7,
        OP_OTP_LOCK = 4'h8
    } flsc_op_t;
    typedef enum logic [1:0] {P_IDLE = 2'h0, P_SETUP = 2'h1, P_STROBE = 2'h3, P_HOLD = 2'h2} flsc_phase_t;
    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] dq_out;
        logic dq_oe;
        logic ce_n;
        logic oe_n;
        logic we_n;
    } flsc_pins_t;
    typedef struct packed {
        logic start;
        logic write;
        logic [23:0] addr;
        logic [15:0] data;
    } flsc_cyc_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } flsc_sw_req_t;
endpackage
`default_nettype wire

// [tb.sv]
/*
 Self-checking bench for flsc_host against the flash model.
 Assumes the host register map and op codes.
*/
`include "flsc_params.svh"
`default_nettype none
module tb;
    import flsc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    flsc_sw_req_t sw_req = '0;
    logic [31:0] sw_rdata, s0, s1;
    logic [15:0] dq_in;
    logic status_output_pin, hard_reset_pin_n;
    flsc_pins_t pins;
    int n_mismatch = 0;
    int n_checks = 0;
    always #5 clk_sys = ~clk_sys;
    // Short poll limit keeps runs brief
    flsc_host #(.POLL_LIMIT(20)) uut (.clk_sys(clk_sys), .reset_n(reset_n), .sw_req(sw_req),
        .sw_rdata(sw_rdata), .dq_in(dq_in), .status_output_pin(status_output_pin), .pins(pins),
        .hard_reset_pin_n(hard_reset_pin_n));
    flsc_flash_model dev (.clk_sys(clk_sys), .pins(pins), .hard_reset_pin_n(hard_reset_pin_n),
        .dq_in(dq_in), .status_output_pin(status_output_pin));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // One-cycle strobes, an idle edge after each
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        sw_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        sw_req.wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        sw_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        sw_req.rd <= 1'b0;
        #1 d = sw_rdata;
        @(posedge clk_sys);
    endtask
    // Issue one op and wait, bounded, until busy drops
    task automatic op(input logic [3:0] o, input logic [23:0] a, input logic [15:0] d);
        logic [31:0] s;
        wr(`FLSC_REG_ADDR, {8'h0, a});
        wr(`FLSC_REG_WDATA, {16'h0, d});
        wr(`FLSC_REG_CTRL, {28'h0, o});
        for (int i = 0; i < 5000; i++) begin
            rd(`FLSC_REG_STATUS, s);
            if (s[0] === 1'b0) return;
        end
        n_mismatch++;
        report_and_stop();
    endtask
    // Idle pins, config shadow, unmapped place, status read in page mode
    task automatic t_reset();
        chk({pins.ce_n, pins.oe_n, pins.we_n, pins.dq_oe, hard_reset_pin_n}, 32'h1D);
        rd(`FLSC_REG_CFG, s0);
        chk(s0, 32'h0);
        wr(`FLSC_REG_CFG, 32'h2);
        rd(`FLSC_REG_CFG, s0);
        chk(s0, 32'h2);
        rd(8'h40, s0);
        chk(s0, 32'h0);
        op(4'h1, 24'h0, 16'h0);
        rd(`FLSC_REG_RDATA, s0);
        chk(s0, 32'h80);
        wr(`FLSC_REG_CFG, 32'h0);
    endtask
    // Status pin code, then lock set and clear as completion events
    task automatic t_pulse(input logic [1:0] c);
        op(4'h5, 24'h0, {14'h0, c});
        rd(`FLSC_REG_STATUS, s0);
        chk(s0[5:4], c);
        op(4'h3, 24'h020000, 16'h0);
        rd(`FLSC_REG_STATUS, s1);
        chk(s1[23:16] - s0[23:16], c[1]);
        chk(s1[15:8], 8'h80);
        op(4'h4, 24'h0, 16'h0);
        rd(`FLSC_REG_STATUS, s0);
        chk(s0[23:16] - s1[23:16], c[0]);
    endtask
    // Program, read back, locked halves, bad index, clear status
    task automatic t_otp();
        op(4'h6, 24'h85, 16'h1234);
        op(4'h7, 24'h85, 16'h0);
        rd(`FLSC_REG_RDATA, s0);
        chk(s0, 32'h1234);
        op(4'h6, 24'h81, 16'h0);
        rd(`FLSC_REG_STATUS, s0);
        chk(s0[15:8], 8'h90);
        op(4'h2, 24'h0, 16'h0);
        op(4'h8, 24'h80, 16'h0);
        op(4'h6, 24'h85, 16'h0);
        rd(`FLSC_REG_STATUS, s0);
        chk(s0[15:8], 8'h90);
        op(4'h6, 24'h8F, 16'h0);
        op(4'h1, 24'h0, 16'h0);
        rd(`FLSC_REG_RDATA, s0);
        chk(s0, 32'h90);
        op(4'h2, 24'h0, 16'h0);
        op(4'h1, 24'h0, 16'h0);
        rd(`FLSC_REG_RDATA, s0);
        chk(s0, 32'h80);
        op(4'h7, 24'h85, 16'h0);
        rd(`FLSC_REG_RDATA, s0);
        chk(s0, 32'h1234);
    endtask
    // Timeout, refusal, hard reset, level mode again
    task automatic t_hrst();
        int n;
        n = 0;
        op(4'h5, 24'h0, 16'h2);
        op(4'h3, 24'h800000, 16'h0);
        rd(`FLSC_REG_STATUS, s1);
        op(4'h3, 24'h0, 16'h0);
        rd(`FLSC_REG_STATUS, s0);
        chk({s1[2:1], s0[2:1]}, 32'h9);
        sw_req <= '{addr: `FLSC_REG_CFG, wdata: 32'h4, wr: 1'b1, rd: 1'b0};
        repeat (40) begin
            @(posedge clk_sys);
            sw_req.wr <= 1'b0;
            #1 n += (hard_reset_pin_n === 1'b0);
        end
        chk(n, 11);
        rd(`FLSC_REG_STATUS, s0);
        chk(s0[5:4], 2'h0);
        rd(`FLSC_REG_CFG, s0);
        chk(s0, 32'h0);
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        t_reset();
        t_pulse(2'h3);
        t_pulse(2'h1);
        t_pulse(2'h2);
        t_pulse(2'h0);
        t_otp();
        t_hrst();
        report_and_stop();
    end
endmodule // tb
`default_nettype wire
